//--- dcs_pkg.sv
`default_nettype none
package dcs_pkg;

  // Byte addresses of the register window
  localparam logic [11:0] ADR_PA_STAT    = 12'h98e;
  localparam logic [11:0] ADR_PB_STAT    = 12'h98f;
  localparam logic [11:0] ADR_START      = 12'h990;
  localparam logic [11:0] ADR_NEXT_B     = 12'h998;
  localparam logic [11:0] ADR_CYC_A      = 12'h9a0;
  localparam logic [11:0] ADR_OFS_B      = 12'h9a4;
  localparam logic [11:0] ADR_CAP_A_CTL  = 12'h9a8;
  localparam logic [11:0] ADR_CAP_B_CTL  = 12'h9a9;
  localparam logic [11:0] ADR_CAP_A_STAT = 12'h9ae;
  localparam logic [11:0] ADR_CAP_B_STAT = 12'h9af;
  localparam logic [11:0] ADR_TS_BASE    = 12'h9b0;
  localparam logic [11:0] ADR_TS_END     = 12'h9cf;

  // Field positions
  localparam int CTL_POS_SINGLE = 0;
  localparam int CTL_NEG_SINGLE = 1;
  localparam int STAT_PENDING   = 0;
  localparam int STAT_POS_EVT   = 0;
  localparam int STAT_NEG_EVT   = 1;
  localparam int STAT_PIN       = 2;
  localparam int LOW_HALF_TOP   = 31;

  // Values after reset
  localparam logic [63:0] RST_TIME64 = 64'h0;
  localparam logic [31:0] RST_TIME32 = 32'h0;
  localparam logic [7:0]  RST_BYTE   = 8'h0;
  localparam logic [1:0]  RST_CTL    = 2'h0;

  // One register access from the network side or the local host interface
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dcs_acc_s;

  // Control bits held outside this block
  typedef struct packed {
    logic pulse_owner_loc;
    logic cap_a_owner_loc;
    logic cap_b_owner_loc;
    logic unit_active;
    logic auto_act_en;
    logic loc_wr_ack;
  } dcs_cfg_s;

  typedef enum logic [1:0] {RUN_IDLE, RUN_FIRST, RUN_CYCLIC} dcs_run_e;

endpackage
`default_nettype wire

//--- dcs_unit.sv
`default_nettype none
module dcs_unit (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire dcs_pkg::dcs_acc_s net_acc,
  input  wire dcs_pkg::dcs_acc_s loc_acc,
  input  wire dcs_pkg::dcs_cfg_s cfg,
  input  wire logic [63:0]       system_time,
  input  wire logic              frame_end,
  input  wire logic [1:0]        cap_pin,
  output logic [7:0]             net_rdata_q,
  output logic [7:0]             loc_rdata_q,
  output logic                   pulse_channel_a_q,
  output logic                   pulse_channel_b_q,
  output logic                   set_active_q,
  output logic                   evt_clr_a_q,
  output logic                   evt_clr_b_q,
  output logic                   cap_irq_net_q,
  output logic                   cap_irq_loc_q
);

  function automatic logic [7:0] get_byte(input logic [63:0] v, input logic [2:0] i);
    get_byte = v[{i, 3'h0} +: 8];
  endfunction

  function automatic logic [63:0] put_byte(input logic [63:0] v, input logic [2:0] i,
                                           input logic [7:0] b);
    put_byte = v;
    put_byte[{i, 3'h0} +: 8] = b;
  endfunction

  dcs_pkg::dcs_run_e run_a_q;
  logic [63:0]       next_a_q;
  logic [63:0]       next_b_q;
  logic [31:0]       cyc_a_q;
  logic [31:0]       ofs_b_q;
  logic              pend_b_q;
  logic              due_b_q;
  logic              lo_wr_q;
  logic              hi_wr_q;
  logic              active_prev_q;
  logic [1:0]        ctl_q   [2];
  logic [1:0]        flag_q  [2];
  logic [1:0]        prev_q;
  logic [63:0]       ts_q    [2][2];
  logic [1:0]        owner_loc;
  logic [1:0]        irq;

  // Pulse unit register writes from the owning side
  dcs_pkg::dcs_acc_s pw;
  logic              pw_start;
  logic              pw_cyc;
  logic              pw_ofs;
  logic [63:0]       start_d;
  logic [63:0]       cyc_d;
  logic [63:0]       ofs_d;
  logic              act_rise;
  logic              fire_a;
  logic              fire_b;
  logic              extend;
  logic [31:0]       ext_hi;
  logic              pend_a;

  assign pw       = cfg.pulse_owner_loc ? loc_acc : net_acc;
  assign pw_start = pw.wr && pw.addr[11:3] == dcs_pkg::ADR_START[11:3]
                    && !cfg.unit_active;
  assign pw_cyc   = pw.wr && pw.addr[11:2] == dcs_pkg::ADR_CYC_A[11:2];
  assign pw_ofs   = pw.wr && pw.addr[11:2] == dcs_pkg::ADR_OFS_B[11:2];
  assign start_d  = put_byte(next_a_q, pw.addr[2:0], pw.wdata);
  assign cyc_d    = put_byte({32'h0, cyc_a_q}, {1'b0, pw.addr[1:0]}, pw.wdata);
  assign ofs_d    = put_byte({32'h0, ofs_b_q}, {1'b0, pw.addr[1:0]}, pw.wdata);
  assign act_rise = cfg.unit_active && !active_prev_q;
  assign pend_a   = run_a_q == dcs_pkg::RUN_FIRST;
  assign fire_a   = cfg.unit_active && run_a_q != dcs_pkg::RUN_IDLE
                    && system_time >= next_a_q;
  assign fire_b   = cfg.unit_active && due_b_q && system_time >= next_b_q;
  // Upper half follows system time, one higher if the low half already wrapped past
  assign ext_hi   = system_time[63:32]
                    + {31'h0, next_a_q[31:0] < system_time[31:0]};
  assign extend   = frame_end && cfg.auto_act_en && lo_wr_q && !hi_wr_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      next_a_q <= dcs_pkg::RST_TIME64;
      run_a_q  <= dcs_pkg::RUN_IDLE;
    end else if (pw_start) begin
      next_a_q <= start_d;
    end else if (extend) begin
      next_a_q <= {ext_hi, next_a_q[31:0]};
    end else if (fire_a) begin
      next_a_q <= next_a_q + {32'h0, cyc_a_q};
      run_a_q  <= cyc_a_q == dcs_pkg::RST_TIME32 ? dcs_pkg::RUN_IDLE
                                                 : dcs_pkg::RUN_CYCLIC;
    end else if (act_rise) begin
      run_a_q  <= dcs_pkg::RUN_FIRST;
    end else if (!cfg.unit_active) begin
      run_a_q  <= dcs_pkg::RUN_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      next_b_q <= dcs_pkg::RST_TIME64;
      pend_b_q <= 1'b0;
      due_b_q  <= 1'b0;
    end else begin
      if (fire_a || act_rise) begin
        next_b_q <= next_a_q + {32'h0, ofs_b_q};
      end
      due_b_q  <= fire_a || (due_b_q && !fire_b && cfg.unit_active);
      pend_b_q <= act_rise || (pend_b_q && !fire_b && cfg.unit_active);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cyc_a_q <= dcs_pkg::RST_TIME32;
      ofs_b_q <= dcs_pkg::RST_TIME32;
    end else begin
      if (pw_cyc) begin
        cyc_a_q <= cyc_d[31:0];
      end
      if (pw_ofs) begin
        ofs_b_q <= ofs_d[31:0];
      end
    end
  end

  // Halves written since the last frame end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lo_wr_q       <= 1'b0;
      hi_wr_q       <= 1'b0;
      active_prev_q <= 1'b0;
      set_active_q  <= 1'b0;
    end else begin
      lo_wr_q       <= !frame_end && (lo_wr_q || (pw_start && !pw.addr[2]));
      hi_wr_q       <= !frame_end && (hi_wr_q || (pw_start && pw.addr[2]));
      active_prev_q <= cfg.unit_active;
      set_active_q  <= frame_end && cfg.auto_act_en && (lo_wr_q || hi_wr_q)
                       && !cfg.unit_active;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pulse_channel_a_q <= 1'b0;
      pulse_channel_b_q <= 1'b0;
    end else begin
      pulse_channel_a_q <= fire_a;
      pulse_channel_b_q <= fire_b;
    end
  end

  // Event request clears from local status accesses
  logic loc_ack_a;
  logic loc_ack_b;
  logic loc_ack;
  assign loc_ack   = cfg.loc_wr_ack ? loc_acc.wr : loc_acc.rd;
  assign loc_ack_a = loc_ack && loc_acc.addr == dcs_pkg::ADR_PA_STAT;
  assign loc_ack_b = loc_ack && loc_acc.addr == dcs_pkg::ADR_PB_STAT;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evt_clr_a_q <= 1'b0;
      evt_clr_b_q <= 1'b0;
    end else begin
      evt_clr_a_q <= loc_ack_a;
      evt_clr_b_q <= loc_ack_b;
    end
  end

  // Capture inputs
  assign owner_loc = {cfg.cap_b_owner_loc, cfg.cap_a_owner_loc};

  for (genvar i = 0; i < 2; i++) begin : g_cap
    dcs_pkg::dcs_acc_s cw;
    logic              cw_ctl;
    logic              own_ack;
    logic [1:0]        edge_hit;
    logic [1:0]        take;
    logic [1:0]        clr;
    logic [11:0]       ts_adr [2];

    assign cw       = owner_loc[i] ? loc_acc : net_acc;
    assign cw_ctl   = cw.wr && cw.addr == dcs_pkg::ADR_CAP_A_CTL + 12'(i);
    assign own_ack  = owner_loc[i] ? loc_ack : net_acc.rd;
    assign edge_hit = {prev_q[i] && !cap_pin[i], cap_pin[i] && !prev_q[i]};
    for (genvar e = 0; e < 2; e++) begin : g_edge
      assign ts_adr[e] = dcs_pkg::ADR_TS_BASE + 12'(16 * i + 8 * e);
      assign clr[e]    = own_ack && cw.addr == ts_adr[e];
      assign take[e]   = edge_hit[e] && !(ctl_q[i][e] && flag_q[i][e]);
    end
    assign irq[i] = |flag_q[i];

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        ctl_q[i]  <= dcs_pkg::RST_CTL;
        flag_q[i] <= dcs_pkg::RST_CTL;
        ts_q[i]   <= '{dcs_pkg::RST_TIME64, dcs_pkg::RST_TIME64};
      end else begin
        if (cw_ctl) begin
          ctl_q[i] <= cw.wdata[1:0];
        end
        // A new edge wins over a clearing read in the same cycle
        flag_q[i] <= ctl_q[i] & (edge_hit | (flag_q[i] & ~clr));
        for (int e = 0; e < 2; e++) begin
          if (take[e]) begin
            ts_q[i][e] <= system_time;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_q        <= 2'h0;
      cap_irq_net_q <= 1'b0;
      cap_irq_loc_q <= 1'b0;
    end else begin
      prev_q        <= cap_pin;
      cap_irq_net_q <= |(irq & ~owner_loc);
      cap_irq_loc_q <= |(irq & owner_loc);
    end
  end

  // Read map shared by both interfaces
  function automatic logic [7:0] rd_map(input logic [11:0] a);
    logic [1:0] ci;
    logic [1:0] te;
    ci = {1'b0, a[0]};
    te = a[4:3] - 2'h2;
    rd_map = dcs_pkg::RST_BYTE;
    if (a == dcs_pkg::ADR_PA_STAT) begin
      rd_map[dcs_pkg::STAT_PENDING] = pend_a;
    end else if (a == dcs_pkg::ADR_PB_STAT) begin
      rd_map[dcs_pkg::STAT_PENDING] = pend_b_q;
    end else if (a[11:3] == dcs_pkg::ADR_START[11:3]) begin
      rd_map = get_byte(next_a_q, a[2:0]);
    end else if (a[11:3] == dcs_pkg::ADR_NEXT_B[11:3]) begin
      rd_map = get_byte(next_b_q, a[2:0]);
    end else if (a[11:3] == dcs_pkg::ADR_CYC_A[11:3]) begin
      rd_map = get_byte({ofs_b_q, cyc_a_q}, a[2:0]);
    end else if (a[11:1] == dcs_pkg::ADR_CAP_A_CTL[11:1]) begin
      rd_map[1:0] = ctl_q[ci[0]];
    end else if (a[11:1] == dcs_pkg::ADR_CAP_A_STAT[11:1]) begin
      rd_map[1:0] = flag_q[ci[0]];
      rd_map[dcs_pkg::STAT_PIN] = cap_pin[ci[0]];
    end else if (a >= dcs_pkg::ADR_TS_BASE && a <= dcs_pkg::ADR_TS_END) begin
      rd_map = get_byte(ts_q[te[1]][te[0]], a[2:0]);
    end
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      net_rdata_q <= dcs_pkg::RST_BYTE;
      loc_rdata_q <= dcs_pkg::RST_BYTE;
    end else begin
      if (net_acc.rd) begin
        net_rdata_q <= rd_map(net_acc.addr);
      end
      if (loc_acc.rd) begin
        loc_rdata_q <= rd_map(loc_acc.addr);
      end
    end
  end

  // Checks
  sequence s_lo_only;
    lo_wr_q && !hi_wr_q && cfg.auto_act_en && frame_end;
  endsequence

  sequence s_fire_cyclic;
    fire_a && cyc_a_q != 32'h0;
  endsequence

  property p_extend;
    @(posedge clk) disable iff (!reset_n)
      (s_lo_only and !pw_start) |=> next_a_q[63:32] == $past(ext_hi);
  endproperty

  property p_spacing;
    @(posedge clk) disable iff (!reset_n)
      (s_fire_cyclic and !pw_start) |=> next_a_q == $past(next_a_q) + {32'h0, $past(cyc_a_q)};
  endproperty

  stat_a_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    loc_acc.rd && loc_acc.addr == dcs_pkg::ADR_PA_STAT |=> loc_rdata_q == {7'h0, $past(pend_a)})
    else $error("channel A status read wrong");
  stat_b_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    net_acc.rd && net_acc.addr == dcs_pkg::ADR_PB_STAT |=> net_rdata_q == {7'h0, $past(pend_b_q)})
    else $error("channel B status read wrong");
  read_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg.loc_wr_ack && loc_acc.rd && loc_acc.addr == dcs_pkg::ADR_PA_STAT |=> evt_clr_a_q)
    else $error("status read did not clear event request");
  ack_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg.loc_wr_ack && loc_acc.addr == dcs_pkg::ADR_PB_STAT |=> evt_clr_b_q == $past(loc_acc.wr))
    else $error("write acknowledge clear wrong");
  start_locked_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg.unit_active && !fire_a && !extend |=> $stable(next_a_q))
    else $error("start time changed while active");
  next_b_ro_a: assert property (@(posedge clk) disable iff (!reset_n)
    !fire_a && !act_rise |=> $stable(next_b_q))
    else $error("next channel B time changed by a write");
  ext_upper_a: assert property (p_extend)
    else $error("upper start time not extended");
  cycle_step_a: assert property (p_spacing)
    else $error("channel A spacing wrong");
  single_shot_a: assert property (@(posedge clk) disable iff (!reset_n)
    fire_a && cyc_a_q == 32'h0 |=> run_a_q == dcs_pkg::RUN_IDLE ##1 !fire_a)
    else $error("single shot fired twice");
  pend_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    fire_a |=> !pend_a && pulse_channel_a_q)
    else $error("pending not cleared after pulse");
  auto_act_a: assert property (@(posedge clk) disable iff (!reset_n)
    frame_end && cfg.auto_act_en && lo_wr_q && !cfg.unit_active |=> set_active_q)
    else $error("auto activation missing");
  single_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctl_q[0][0] && flag_q[0][0] |=> $stable(ts_q[0][0]))
    else $error("single event capture overwritten");
  irq_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    irq[1] && !cfg.cap_b_owner_loc |=> cap_irq_net_q)
    else $error("capture interrupt misrouted");

endmodule
`default_nettype wire

//--- dcs_host_model.sv
`default_nettype none
module dcs_host_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       act_set,
  input  wire logic       act_clr,
  input  wire logic       set_active_q,
  input  wire logic       pulse_a,
  input  wire logic       pulse_b,
  input  wire logic       evt_clr_a_q,
  input  wire logic       evt_clr_b_q,
  output logic            unit_active_q,
  output logic [1:0]      evt_req_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // Activation bit, set on request of the block or the bench
  always_ff @(posedge clk) begin
    if (!reset_n || act_clr) begin
      unit_active_q <= 1'b0;
    end else if (set_active_q || act_set) begin
      unit_active_q <= 1'b1;
    end
  end
  // Event request bits, raised by pulses, dropped by acknowledges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evt_req_q <= 2'h0;
    end else begin
      // A new pulse wins over an acknowledge in the same cycle
      evt_req_q[0] <= (evt_req_q[0] & ~evt_clr_a_q) | pulse_a;
      evt_req_q[1] <= (evt_req_q[1] & ~evt_clr_b_q) | pulse_b;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  dcs_pkg::dcs_acc_s net_acc = '0;
  dcs_pkg::dcs_acc_s loc_acc = '0;
  logic              own_p = 1'b0, own_a = 1'b0, own_b = 1'b0, auto_en = 1'b0, wr_ack = 1'b0;
  logic [63:0]       system_time = 64'h0000_0005_ffff_0000;
  logic              frame_end = 1'b0, act_set = 1'b0, act_clr = 1'b0;
  logic [1:0]        cap_pin = 2'h0;
  logic [7:0]        net_rdata_q, loc_rdata_q;
  logic              pa, pb, set_active_q, clr_a, clr_b, irq_net, irq_loc, unit_active;
  logic [1:0]        evt_req;
  logic [63:0]       edge_t = 64'h0;
  int                err_total = 0;
  int                check_count = 0;
  int                cyc = 0;
  dcs_unit dut (
    .clk(clk), .reset_n(reset_n), .net_acc(net_acc), .loc_acc(loc_acc),
    .cfg(dcs_pkg::dcs_cfg_s'({own_p, own_a, own_b, unit_active, auto_en, wr_ack})),
    .system_time(system_time), .frame_end(frame_end), .cap_pin(cap_pin),
    .net_rdata_q(net_rdata_q), .loc_rdata_q(loc_rdata_q), .pulse_channel_a_q(pa),
    .pulse_channel_b_q(pb), .set_active_q(set_active_q), .evt_clr_a_q(clr_a),
    .evt_clr_b_q(clr_b), .cap_irq_net_q(irq_net), .cap_irq_loc_q(irq_loc));
  dcs_host_model host (
    .clk(clk), .reset_n(reset_n), .act_set(act_set), .act_clr(act_clr),
    .set_active_q(set_active_q), .pulse_a(pa), .pulse_b(pb), .evt_clr_a_q(clr_a),
    .evt_clr_b_q(clr_b), .unit_active_q(unit_active), .evt_req_q(evt_req));
  always #25 clk = ~clk;
  always @(posedge clk) cyc++;
  // System time advances by one clock period in ns
  always @(negedge clk) system_time <= system_time + 64'd50;

  task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One byte access, held over one rising edge; read data taken one cycle later
  task automatic acc(input bit loc, input bit wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    dcs_pkg::dcs_acc_s r;
    r = '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(negedge clk);
    if (loc) loc_acc = r; else net_acc = r;
    @(negedge clk);
    q = loc ? loc_rdata_q : net_rdata_q;
    if (loc) loc_acc = '0; else net_acc = '0;
  endtask
  task automatic rdn(input bit loc, input logic [11:0] a, input int n, output logic [63:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < n; i++) begin
      acc(loc, 1'b0, a + 12'(i), 8'h0, b);
      v[8*i+:8] = b;
    end
  endtask
  task automatic wrn(input bit loc, input logic [11:0] a, input int n, input logic [63:0] v);
    logic [7:0] b;
    for (int i = 0; i < n; i++) acc(loc, 1'b1, a + 12'(i), v[8*i+:8], b);
  endtask
  task automatic wait_a(output int n);
    n = 0;
    while (pa !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("pulse_a_seen", 64'(pa), 64'h1);
  endtask
  task automatic t_reset();
    logic [11:0] ra [10] = '{dcs_pkg::ADR_PA_STAT, dcs_pkg::ADR_PB_STAT, dcs_pkg::ADR_START,
      dcs_pkg::ADR_NEXT_B, dcs_pkg::ADR_CYC_A, dcs_pkg::ADR_OFS_B, dcs_pkg::ADR_CAP_A_CTL,
      dcs_pkg::ADR_CAP_B_CTL, dcs_pkg::ADR_CAP_A_STAT, dcs_pkg::ADR_CAP_B_STAT};
    logic [63:0] v;
    foreach (ra[i]) begin
      rdn(1'b0, ra[i], 1, v);
      chk("reset_value", v, 64'h0);
    end
    $display("reset_values done");
  endtask
  task automatic t_regs();
    logic [63:0] v;
    wrn(1'b1, dcs_pkg::ADR_CYC_A, 4, 64'h1122_3344);
    wrn(1'b0, dcs_pkg::ADR_CYC_A, 4, 64'd5000);
    wrn(1'b0, dcs_pkg::ADR_OFS_B, 4, 64'd300);
    rdn(1'b1, dcs_pkg::ADR_CYC_A, 4, v);
    chk("cycle_owner", v, 64'd5000);
    wrn(1'b0, dcs_pkg::ADR_NEXT_B, 1, 64'hff);
    rdn(1'b0, dcs_pkg::ADR_NEXT_B, 1, v);
    chk("next_b_ro", v, 64'h0);
    $display("register_access done");
  endtask
  task automatic t_pulse();
    logic [63:0] v, st, exp;
    int n, c0;
    auto_en = 1'b1;
    wrn(1'b0, dcs_pkg::ADR_START, 4, 64'h800);
    @(negedge clk);
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
    st = system_time;
    exp = {st[63:32] + 32'(32'h800 < st[31:0]), 32'h800};
    chk("set_active", 64'(set_active_q), 64'h1);
    wrn(1'b0, dcs_pkg::ADR_START, 1, 64'haa);
    rdn(1'b0, dcs_pkg::ADR_PA_STAT, 1, v);
    chk("pending_a", v, 64'h1);
    rdn(1'b0, dcs_pkg::ADR_PB_STAT, 1, v);
    chk("pending_b", v, 64'h1);
    rdn(1'b0, dcs_pkg::ADR_START, 8, v);
    chk("start_ext", v, exp);
    wait_a(n);
    c0 = cyc;
    rdn(1'b0, dcs_pkg::ADR_PA_STAT, 1, v);
    chk("pending_a_done", v, 64'h0);
    rdn(1'b1, dcs_pkg::ADR_START, 8, v);
    chk("next_a", v, exp + 64'd5000);
    rdn(1'b0, dcs_pkg::ADR_NEXT_B, 8, v);
    chk("next_b", v, exp + 64'd300);
    wait_a(n);
    chk("period_a", 64'(cyc - c0), 64'd100);
    repeat (10) @(negedge clk);
    act_clr = 1'b1;
    @(negedge clk);
    act_clr = 1'b0;
    auto_en = 1'b0;
    $display("cyclic_pulses done");
  endtask
  task automatic stat(input bit loc, input bit wr, input logic [11:0] a, input logic [1:0] e);
    logic [7:0] b;
    acc(loc, wr, a, 8'h5a, b);
    @(negedge clk);
    chk("event_request", 64'(evt_req), 64'(e));
  endtask
  task automatic t_status();
    chk("event_request_set", 64'(evt_req), 64'h3);
    stat(1'b0, 1'b0, dcs_pkg::ADR_PA_STAT, 2'h3);
    stat(1'b1, 1'b1, dcs_pkg::ADR_PA_STAT, 2'h3);
    stat(1'b1, 1'b0, dcs_pkg::ADR_PA_STAT, 2'h2);
    wr_ack = 1'b1;
    stat(1'b1, 1'b0, dcs_pkg::ADR_PB_STAT, 2'h2);
    stat(1'b1, 1'b1, dcs_pkg::ADR_PB_STAT, 2'h0);
    wr_ack = 1'b0;
    $display("status_clear done");
  endtask
  task automatic t_single();
    int cnt;
    wrn(1'b0, dcs_pkg::ADR_CYC_A, 4, 64'h0);
    wrn(1'b0, dcs_pkg::ADR_START, 8, system_time + 64'd3000);
    @(negedge clk);
    act_set = 1'b1;
    @(negedge clk);
    act_set = 1'b0;
    cnt = 0;
    repeat (300) begin
      @(negedge clk);
      if (pa === 1'b1) cnt++;
    end
    chk("single_shot", 64'(cnt), 64'h1);
    act_clr = 1'b1;
    @(negedge clk);
    act_clr = 1'b0;
    $display("single_shot done");
  endtask
  task automatic pin(input int i, input logic l);
    @(negedge clk);
    cap_pin[i] = l;
    // Stamp is taken at the next rising edge, one time step on
    edge_t = system_time + 64'd50;
    repeat (2) @(negedge clk);
  endtask
  task automatic cst(input bit loc, input logic [11:0] a, input logic [7:0] e);
    logic [63:0] v;
    rdn(loc, a, 1, v);
    chk("capture_reg", v, 64'(e));
  endtask
  task automatic t_cap();
    logic [63:0] v, ts_pos, ts_neg;
    own_a = 1'b1;
    wrn(1'b0, dcs_pkg::ADR_CAP_A_CTL, 1, 64'h3);
    cst(1'b1, dcs_pkg::ADR_CAP_A_CTL, 8'h0);
    wrn(1'b1, dcs_pkg::ADR_CAP_A_CTL, 1, 64'h3);
    cst(1'b1, dcs_pkg::ADR_CAP_A_CTL, 8'h3);
    pin(0, 1'b1);
    ts_pos = edge_t;
    cst(1'b1, dcs_pkg::ADR_CAP_A_STAT, 8'h5);
    chk("irq_route", {irq_net, irq_loc}, 64'h1);
    pin(0, 1'b0);
    ts_neg = edge_t;
    pin(0, 1'b1);
    pin(0, 1'b0);
    cst(1'b1, dcs_pkg::ADR_CAP_A_STAT, 8'h3);
    rdn(1'b1, dcs_pkg::ADR_TS_BASE, 8, v);
    chk("stamp_a_pos", v, ts_pos);
    cst(1'b1, dcs_pkg::ADR_CAP_A_STAT, 8'h2);
    rdn(1'b1, dcs_pkg::ADR_TS_BASE + 12'h8, 8, v);
    chk("stamp_a_neg", v, ts_neg);
    cst(1'b1, dcs_pkg::ADR_CAP_A_STAT, 8'h0);
    wrn(1'b1, dcs_pkg::ADR_CAP_A_CTL, 1, 64'h0);
    pin(0, 1'b1);
    cst(1'b0, dcs_pkg::ADR_CAP_A_STAT, 8'h4);
    pin(0, 1'b0);
    wrn(1'b1, dcs_pkg::ADR_CAP_B_CTL, 1, 64'h2);
    cst(1'b0, dcs_pkg::ADR_CAP_B_CTL, 8'h0);
    wrn(1'b0, dcs_pkg::ADR_CAP_B_CTL, 1, 64'h2);
    pin(1, 1'b1);
    pin(1, 1'b0);
    cst(1'b0, dcs_pkg::ADR_CAP_B_STAT, 8'h2);
    chk("irq_route_b", {irq_net, irq_loc}, 64'h2);
    rdn(1'b0, dcs_pkg::ADR_TS_BASE + 12'h18, 1, v);
    cst(1'b0, dcs_pkg::ADR_CAP_B_STAT, 8'h0);
    $display("capture_inputs done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_pulse();
    t_status();
    t_single();
    t_cap();
    results();
  end
endmodule
`default_nettype wire
